/* File: pkg/gfe_defs.svh */
// constants for the falling-edge pin interrupt block
`ifndef GFE_DEFS_SVH
`define GFE_DEFS_SVH

`define GFE_ADDR_W 4
`define GFE_DATA_W 32
`define GFE_PINS 32
`define GFE_BE_W 4

`define GFE_OFS_FALL_SET 4'h0
`define GFE_OFS_FALL_CLR 4'h4
`define GFE_OFS_PEND 4'h8

`define GFE_BANK1_MSB 31
`define GFE_BANK1_LSB 16
`define GFE_BANK0_MSB 15
`define GFE_BANK0_LSB 0

`define GFE_RST_ENABLE 32'h00000000
`define GFE_RST_PEND 32'h00000000
`define GFE_RST_RDATA 32'h00000000
`define GFE_RST_PINS 32'h00000000
`define GFE_RST_WAIT 2'h0
`define GFE_WAIT_STATES 2'h1

`endif

/* File: pkg/gfe_pkg.sv */
// types shared by the falling-edge pin interrupt block
`default_nettype none
`include "gfe_defs.svh"

package gfe_pkg;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_SET = 2'b01,
    SEL_CLR = 2'b10,
    SEL_PEND = 2'b11
  } gfe_reg_sel_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } gfe_bus_state_t;

endpackage : gfe_pkg

`default_nettype wire

/* File: pkg/gfe_pin_if.sv */
// carrier for synchronised pin edge events
`timescale 1ns/1ps
`default_nettype none
`include "gfe_defs.svh"

interface gfe_pin_if;
  logic [`GFE_PINS-1:0] fell;
  modport src (output fell);
  modport dst (input fell);
endinterface : gfe_pin_if

`default_nettype wire

/* File: hdl/gfe_pin_sync.sv */
// two-flop pin synchroniser with falling-edge detector
`timescale 1ns/1ps
`default_nettype none
`include "gfe_defs.svh"

module gfe_pin_sync
  import gfe_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // raw pins
  input wire logic [`GFE_PINS-1:0] pin_raw,
  // edge events
  gfe_pin_if.src pins
);

  logic [`GFE_PINS-1:0] meta_r;
  logic [`GFE_PINS-1:0] sync_r;
  logic [`GFE_PINS-1:0] prev_r;

  // meta_r feeds sync_r only
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= `GFE_RST_PINS;
      sync_r <= `GFE_RST_PINS;
    end
    else
    begin
      meta_r <= pin_raw;
      sync_r <= meta_r;
    end
  end

  // reset low so a pin high at reset gives no false edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prev_r <= `GFE_RST_PINS;
    else
      prev_r <= sync_r;
  end

  // high-to-low on the synchronised level
  assign pins.fell = prev_r & ~sync_r;

endmodule : gfe_pin_sync

`default_nettype wire

/* File: hdl/gfe_falling_edge_irq.sv */
// falling-edge pin interrupt detector with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "gfe_defs.svh"
// Overview of operation
// - set register ones enable falling detection
// - enabled pin falling edge raises interrupt
// - set register reads the true enable
// - bits 31-16 bank 1, 15-0 bank 0
// - clear register ones disable falling detection
// - disabled pin falling edge raises nothing
// - clear register reads inverted enable
// - status bit reads 1 while pending
// - status reads 0 otherwise, zero after reset
// - status write one clears, zero keeps

module gfe_falling_edge_irq
  import gfe_pkg::*;
(
  // system
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [`GFE_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`GFE_BE_W-1:0] avs_byteenable,
  input wire logic [`GFE_DATA_W-1:0] avs_writedata,
  output logic [`GFE_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // general-purpose pins
  input wire logic [`GFE_PINS-1:0] gpio_pin,
  // pending view
  output logic [`GFE_PINS-1:0] pin_pending_bits
);

  function automatic gfe_reg_sel_t reg_decode(input logic [`GFE_ADDR_W-1:0] addr);
    gfe_reg_sel_t sel;
    sel = SEL_NONE;
    // unaligned or unknown offsets fall to none
    case (addr)
      `GFE_OFS_FALL_SET: sel = SEL_SET;
      `GFE_OFS_FALL_CLR: sel = SEL_CLR;
      `GFE_OFS_PEND: sel = SEL_PEND;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction : reg_decode

  function automatic logic [`GFE_DATA_W-1:0] lane_mask(input logic [`GFE_BE_W-1:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  gfe_pin_if pins ();

  gfe_pin_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_raw(gpio_pin),
    .pins(pins)
  );

  gfe_bus_state_t state_r;
  gfe_bus_state_t state_nxt;
  gfe_reg_sel_t sel;
  logic bus_req;
  logic rd_capture;
  logic wr_commit;
  logic wr_set;
  logic wr_clr;
  logic wr_pend;
  logic [`GFE_DATA_W-1:0] wbits;
  logic [`GFE_PINS-1:0] en_r;
  logic [`GFE_PINS-1:0] en_nxt;
  logic [`GFE_PINS-1:0] pend_r;
  logic [`GFE_PINS-1:0] pend_nxt;
  logic [`GFE_PINS-1:0] fall_evt;
  logic [`GFE_DATA_W-1:0] rdata_r;
  logic [`GFE_DATA_W-1:0] rdata_nxt;

  // master never raises read and write together
  assign bus_req = avs_read | avs_write;
  assign sel = reg_decode(avs_address);
  assign wbits = avs_writedata & lane_mask(avs_byteenable);

  // fixed single wait state: data is registered before the answer edge
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      BUS_IDLE:
      begin
        if (bus_req)
          state_nxt = BUS_ANSWER;
      end
      BUS_ANSWER:
      begin
        state_nxt = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      state_r <= BUS_IDLE;
    else
      state_r <= state_nxt;
  end

  assign avs_waitrequest = bus_req & (state_r == BUS_IDLE);
  assign rd_capture = avs_read & (state_r == BUS_IDLE);
  assign wr_commit = avs_write & (state_r == BUS_ANSWER);
  assign wr_set = wr_commit & (sel == SEL_SET);
  assign wr_clr = wr_commit & (sel == SEL_CLR);
  assign wr_pend = wr_commit & (sel == SEL_PEND);

  // both registers steer the same enable flops
  always_comb
  begin
    en_nxt = en_r;
    if (wr_set)
      en_nxt = en_r | wbits;
    if (wr_clr)
      en_nxt = en_r & ~wbits;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      en_r <= `GFE_RST_ENABLE;
    else
      en_r <= en_nxt;
  end

  // only enabled pins may raise a pending bit
  assign fall_evt = en_r & pins.fell;

  // an edge in the clearing cycle survives: set wins over clear
  always_comb
  begin
    pend_nxt = pend_r;
    if (wr_pend)
      pend_nxt = pend_r & ~wbits;
    pend_nxt = pend_nxt | fall_evt;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pend_r <= `GFE_RST_PEND;
    else
      pend_r <= pend_nxt;
  end

  // bit i is the same pin in every register: bank 1 high half, bank 0 low half
  always_comb
  begin
    rdata_nxt = rdata_r;
    if (rd_capture)
    begin
      unique case (sel)
        SEL_SET: rdata_nxt = en_r;
        SEL_CLR: rdata_nxt = ~en_r;
        SEL_PEND: rdata_nxt = pend_r;
        SEL_NONE: rdata_nxt = `GFE_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_r <= `GFE_RST_RDATA;
    else
      rdata_r <= rdata_nxt;
  end

  assign avs_readdata = rdata_r;
  assign pin_pending_bits = pend_r;

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (rst);

  a_set_enables: assert property (
    wr_set |=> en_r == ($past(en_r) | $past(wbits))
  ) else $error("set register write did not enable the pins");

  a_clr_disables: assert property (
    wr_clr |=> en_r == ($past(en_r) & ~$past(wbits))
  ) else $error("clear register write did not disable the pins");

  a_enable_steady: assert property (
    !wr_set && !wr_clr |=> $stable(en_r)
  ) else $error("enable changed without a register write");

  a_fall_pends: assert property (
    fall_evt != '0 |=> (pend_r & $past(fall_evt)) == $past(fall_evt)
  ) else $error("enabled falling edge did not set pending next clock");

  a_disabled_quiet: assert property (
    ##1 (pend_r & ~$past(pend_r) & ~$past(en_r & pins.fell)) == '0
  ) else $error("pending bit rose without an enabled falling edge");

  a_w1c_clears: assert property (
    wr_pend |=> (pend_r & $past(wbits) & ~$past(fall_evt)) == '0
      && (pend_r & $past(pend_r & ~wbits)) == $past(pend_r & ~wbits)
  ) else $error("status write-one-to-clear misbehaved");

  a_set_readback: assert property (
    rd_capture && sel == SEL_SET |=> !avs_waitrequest && avs_readdata == en_r
  ) else $error("set register read is not the enable state");

  a_clr_readback: assert property (
    rd_capture && sel == SEL_CLR |=> !avs_waitrequest && avs_readdata == ~en_r
  ) else $error("clear register read is not the inverted enable");

  a_pend_readback: assert property (
    rd_capture && sel == SEL_PEND |=> avs_readdata == $past(pend_r)
  ) else $error("status read does not match pending bits");

  a_bank_halves: assert property (
    rd_capture && sel == SEL_PEND |=> avs_readdata[`GFE_BANK1_MSB:`GFE_BANK1_LSB]
      == $past(pin_pending_bits[`GFE_BANK1_MSB:`GFE_BANK1_LSB])
      && avs_readdata[`GFE_BANK0_MSB:`GFE_BANK0_LSB]
      == $past(pin_pending_bits[`GFE_BANK0_MSB:`GFE_BANK0_LSB])
  ) else $error("bank halves are not in place");

  a_answer_next: assert property (
    bus_req && avs_waitrequest |=> !avs_waitrequest ##1 state_r == BUS_IDLE
  ) else $error("bus answer did not come after one wait state");

  // run length of waitrequest; a stuck slave would hang the master
  logic [1:0] wait_cnt_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wait_cnt_r <= `GFE_RST_WAIT;
    else if (!avs_waitrequest)
      wait_cnt_r <= `GFE_RST_WAIT;
    else if (wait_cnt_r != 2'h3)
      wait_cnt_r <= wait_cnt_r + 2'h1;
  end

  property p_wait_bounded;
    wait_cnt_r <= `GFE_WAIT_STATES;
  endproperty
  a_wait_bounded: assert property (p_wait_bounded)
    else $error("waitrequest held longer than one cycle");

  property p_idle_released;
    !bus_req |-> !avs_waitrequest;
  endproperty
  a_idle_released: assert property (p_idle_released)
    else $error("waitrequest high with no request");

  property p_answer_returns;
    state_r == BUS_ANSWER |=> state_r == BUS_IDLE;
  endproperty
  a_answer_returns: assert property (p_answer_returns)
    else $error("bus did not return to idle after the answer");

  property p_rdata_holds;
    !rd_capture |=> $stable(avs_readdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data changed without a read capture");

  property p_unmapped_keeps;
    wr_commit && sel == SEL_NONE |=> $stable(en_r);
  endproperty
  a_unmapped_keeps: assert property (p_unmapped_keeps)
    else $error("unmapped write changed the enables");

  property p_pend_sticky;
    !wr_pend |=> (pend_r & $past(pend_r)) == $past(pend_r);
  endproperty
  a_pend_sticky: assert property (p_pend_sticky)
    else $error("pending bit dropped without a clearing write");

  property p_set_wins;
    wr_pend && fall_evt != '0 |=> (pend_r & $past(fall_evt)) == $past(fall_evt);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("edge in the clearing cycle was lost");

  property p_zero_keeps;
    wr_pend |=> (pend_r & ~$past(wbits)) == ($past(pend_r | fall_evt) & ~$past(wbits));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps)
    else $error("status write of zero changed a pending bit");

  property p_edge_pulse;
    (pins.fell & $past(pins.fell)) == '0;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse)
    else $error("falling event lasted more than one cycle");

  property p_lanes_keep;
    wr_commit |=> ((en_r ^ $past(en_r)) & ~$past(lane_mask(avs_byteenable))) == '0;
  endproperty
  a_lanes_keep: assert property (p_lanes_keep)
    else $error("write changed enables in a disabled byte lane");

  property p_reset_clean;
    disable iff (1'b0) rst |=> en_r == '0 && pend_r == '0 && avs_readdata == '0;
  endproperty
  a_reset_clean: assert property (p_reset_clean)
    else $error("registers not cleared by reset");

  property p_read_keeps;
    avs_read |=> $stable(en_r);
  endproperty
  a_read_keeps: assert property (p_read_keeps)
    else $error("a read changed the enables");

  c_edge_pending: cover property (
    fall_evt != '0 ##1 pend_r != '0
  );

  c_clear_with_edge: cover property (
    wr_pend && (wbits & fall_evt) != '0
  );

  c_clear_read: cover property (
    rd_capture && sel == SEL_CLR ##1 avs_readdata != '1
  );

  c_back_to_back: cover property (
    wr_commit ##1 rd_capture
  );

  c_lane_write: cover property (
    wr_commit && avs_byteenable != 4'hF
  );

endmodule : gfe_falling_edge_irq

`default_nettype wire

/* File: testbench/gfe_pin_model.sv */
// behavioural model of the external pins
`timescale 1ns/1ps
`default_nettype none

module gfe_pin_model
(
  // system
  input wire logic clk_sys,
  // requested levels
  input wire logic [31:0] level_req,
  // driven pins
  output logic [31:0] gpio_pin
);
  // pins move just after an edge, like a real board signal
  always_ff @(posedge clk_sys)
  begin
    gpio_pin <= level_req;
  end
endmodule : gfe_pin_model

`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the falling-edge pin interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "gfe_defs.svh"

module tb_top
  import gfe_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] gpio_pin;
  logic [31:0] level_req = 32'hFFFFFFFF;
  logic [31:0] pin_pending_bits;
  logic [31:0] exp_q[$];
  logic [31:0] d, c, e, m;
  integer seed = 32'hd1e4;
  integer num_errors = 0;
  integer checked = 0;
  integer cycles = 0;

  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end

  gfe_falling_edge_irq uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gpio_pin(gpio_pin),
    .pin_pending_bits(pin_pending_bits));

  gfe_pin_model pins (.clk_sys(clk_sys), .level_req(level_req), .gpio_pin(gpio_pin));

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one avalon transfer; reads queue their expectation
  task automatic bus(input int w, input logic [3:0] a, input logic [31:0] wd, input logic [31:0] ex);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w != 0;
    avs_read <= w == 0;
    avs_writedata <= wd;
    if (w == 0)
      exp_q.push_back(ex);
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // read data taken at the edge where waitrequest is seen low
  always @(posedge clk_sys)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      chk("readdata", avs_readdata, exp_q.pop_front());
  end

  task automatic print_verdict;
    if (exp_q.size() != 0)
      num_errors = num_errors + 1;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // hang guard well above the hundred or so cycles the run needs
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    bus(0, `GFE_OFS_FALL_SET, 0, 32'h0);
    bus(0, `GFE_OFS_FALL_CLR, 0, 32'hFFFFFFFF);
    bus(0, `GFE_OFS_PEND, 0, 32'h0);
    bus(0, 4'hC, 0, 32'h0);
    d = $random(seed);
    c = $random(seed);
    m = $random(seed);
    bus(1, `GFE_OFS_FALL_SET, d, 0);
    bus(0, `GFE_OFS_FALL_SET, 0, d);
    bus(0, `GFE_OFS_FALL_CLR, 0, ~d);
    bus(1, `GFE_OFS_FALL_SET, 32'h0, 0);
    bus(1, `GFE_OFS_FALL_CLR, c, 0);
    e = d & ~c;
    bus(0, `GFE_OFS_FALL_SET, 0, e);
    bus(0, `GFE_OFS_FALL_CLR, 0, ~e);
    // every pin falls; only enabled ones may latch
    level_req <= 32'h0;
    repeat (6) @(posedge clk_sys);
    bus(0, `GFE_OFS_PEND, 0, e);
    bus(1, `GFE_OFS_PEND, m, 0);
    bus(0, `GFE_OFS_PEND, 0, e & ~m);
    bus(1, `GFE_OFS_PEND, 32'h0, 0);
    bus(0, `GFE_OFS_PEND, 0, e & ~m);
    bus(1, `GFE_OFS_PEND, 32'hFFFFFFFF, 0);
    bus(0, `GFE_OFS_PEND, 0, 32'h0);
    // bank 0 only through byte lanes, then fall all pins again
    bus(1, `GFE_OFS_FALL_CLR, 32'hFFFFFFFF, 0);
    avs_byteenable <= 4'h3;
    bus(1, `GFE_OFS_FALL_SET, 32'hFFFFFFFF, 0);
    avs_byteenable <= 4'hF;
    bus(0, `GFE_OFS_FALL_SET, 0, 32'h0000FFFF);
    level_req <= 32'hFFFFFFFF;
    repeat (4) @(posedge clk_sys);
    level_req <= 32'h0;
    repeat (6) @(posedge clk_sys);
    bus(0, `GFE_OFS_PEND, 0, 32'h0000FFFF);
    chk("pin_pending_bits", pin_pending_bits, 32'h0000FFFF);
    repeat (2) @(posedge clk_sys);
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
